// File: src/fswg_guard.sv
// Flash section write guard: section sizing from fuses, write permission and stall.
// Assumes the core holds a request until accept or refuse is pulsed.
// Function
// - Flash pages are 512 bytes
// - Erase covers whole pages only
// - Writes are one byte or word
// - No write to executing section
// - Code section writable only from loader
// - Data section writable from loader or code
// - Stall for non-debug Flash, not EEPROM; data-run refused
// - Section sizes from fuses, 512-byte blocks
// - Loader, code, data sections in order
// - Loader fuse zero: all loader
// - Code fuse zero: code to end
// - Code fuse not above loader: no code
// - Vectors at code start, relocatable
// - Oversized fuse falls back to default
// - EEPROM programs while core runs
// - Chip erase refused outside debug; debug writes
`timescale 1ns/1ps
`include "fswg_regs.svh"
module fswg_guard #(
	parameter int ADDR_W = `FSWG_ADDR_W,
	parameter int FLASH_PAGES = `FSWG_FLASH_PAGES,
	parameter int PROG_CYC = `FSWG_FLASH_PROG_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SRST_IN,
	// Fuses and vector control
	input wire logic [7:0] LOADER_SIZE_FUSE_IN,
	input wire logic [7:0] CODE_SIZE_FUSE_IN,
	input wire logic VECTOR_RELOCATE_BIT_IN,
	// Core fetch
	input wire logic [ADDR_W-1:0] FETCH_ADDR_IN,
	// Core write request
	input wire logic REQ_VALID_IN,
	input wire fswg_pkg::fswg_op_t REQ_OP_IN,
	input wire logic REQ_EEPROM_IN,
	input wire logic REQ_CHIP_ERASE_IN,
	input wire logic REQ_USER_ROW_IN,
	input wire logic REQ_DEBUG_IN,
	input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
	input wire logic [5:0] REQ_PAGES_IN,
	// Answer
	output logic REQ_ACCEPT_OUT,
	output logic REQ_REFUSE_OUT,
	output logic CPU_STALL_OUT,
	// Memory program strobe
	output logic MEM_PROG_OUT,
	output logic MEM_FLASH_OUT,
	output logic MEM_USER_ROW_OUT,
	output logic [ADDR_W-1:0] MEM_ADDR_OUT,
	output logic [5:0] MEM_PAGES_OUT,
	// Layout
	output logic [ADDR_W:0] LOADER_END_OUT,
	output logic [ADDR_W:0] APP_CODE_END_OUT,
	output logic [ADDR_W-1:0] VECTOR_BASE_OUT,
	output fswg_pkg::fswg_sec_t EXEC_SEC_OUT
);
	import fswg_pkg::*;
	localparam logic [ADDR_W:0] FLASH_END_B = (ADDR_W+1)'(FLASH_PAGES * `FSWG_PAGE_BYTES);
	typedef struct packed {
		logic loaded;
		logic [ADDR_W:0] loader_end;
		logic [ADDR_W:0] app_code_end;
		logic busy;
		logic [15:0] cnt;
		logic accept;
		logic refuse;
		logic prog;
		logic flash;
		logic user_row;
		logic [ADDR_W-1:0] addr;
		logic [5:0] pages;
	} fswg_state_t;
	fswg_state_t s_q;
	fswg_state_t s_d;
	fswg_sec_t exec_sec;
	fswg_sec_t tgt_sec;
	logic [ADDR_W+8:0] lsz;
	logic [ADDR_W+8:0] csz;
	logic [ADDR_W:0] le;
	logic [ADDR_W:0] ae;
	logic allowed;
	logic is_flash;
	fswg_sec_decode #(.ADDR_W(ADDR_W)) u_exec (
		.addr_in(FETCH_ADDR_IN),
		.loader_end_in(s_q.loader_end),
		.app_code_end_in(s_q.app_code_end),
		.sec_out(exec_sec)
	);
	fswg_sec_decode #(.ADDR_W(ADDR_W)) u_tgt (
		.addr_in(REQ_ADDR_IN),
		.loader_end_in(s_q.loader_end),
		.app_code_end_in(s_q.app_code_end),
		.sec_out(tgt_sec)
	);
	// Boundaries from fuses in 512-byte blocks
	always_comb begin
		lsz = (ADDR_W+9)'(LOADER_SIZE_FUSE_IN) << `FSWG_PAGE_SHIFT;
		if (lsz > (ADDR_W+9)'(FLASH_END_B)) begin
			lsz = (ADDR_W+9)'(`FSWG_LOADER_FUSE_DEF) << `FSWG_PAGE_SHIFT;
		end
		csz = (ADDR_W+9)'(CODE_SIZE_FUSE_IN) << `FSWG_PAGE_SHIFT;
		if (csz > (ADDR_W+9)'(FLASH_END_B)) begin
			csz = (ADDR_W+9)'(`FSWG_CODE_FUSE_DEF) << `FSWG_PAGE_SHIFT;
		end
		if (lsz == '0) begin
			le = FLASH_END_B;
			ae = FLASH_END_B;
		end else if (csz == '0) begin
			le = lsz[ADDR_W:0];
			ae = FLASH_END_B;
		end else if (csz <= lsz) begin
			le = lsz[ADDR_W:0];
			ae = lsz[ADDR_W:0];
		end else begin
			le = lsz[ADDR_W:0];
			ae = csz[ADDR_W:0];
		end
	end
	// Permission table
	always_comb begin
		is_flash = !REQ_EEPROM_IN && !REQ_USER_ROW_IN;
		if (REQ_DEBUG_IN) begin
			allowed = 1'b1;
		end else if (exec_sec == FSWG_SEC_DATA) begin
			allowed = 1'b0;
		end else if (REQ_CHIP_ERASE_IN || !is_flash) begin
			allowed = !REQ_CHIP_ERASE_IN;
		end else begin
			unique case (tgt_sec)
				FSWG_SEC_CODE: allowed = (exec_sec == FSWG_SEC_LOADER);
				FSWG_SEC_DATA: allowed = 1'b1;
				default: allowed = 1'b0;
			endcase
		end
	end
	always_comb begin
		s_d = s_q;
		s_d.accept = 1'b0;
		s_d.refuse = 1'b0;
		s_d.prog = 1'b0;
		if (!s_q.loaded) begin
			s_d.loaded = 1'b1;
			s_d.loader_end = le;
			s_d.app_code_end = ae;
		end else if (s_q.busy) begin
			if (s_q.cnt == 16'h0001) begin
				s_d.busy = 1'b0;
				s_d.accept = 1'b1;
			end
			s_d.cnt = s_q.cnt - 16'h0001;
		end else if (REQ_VALID_IN) begin
			if (!allowed) begin
				s_d.refuse = 1'b1;
			end else begin
				s_d.prog = 1'b1;
				s_d.flash = is_flash;
				s_d.user_row = REQ_USER_ROW_IN;
				s_d.addr = REQ_ADDR_IN;
				s_d.pages = 6'h01;
				if (REQ_OP_IN == FSWG_OP_ERASE) begin
					// Erase aligns to whole pages
					s_d.addr = {REQ_ADDR_IN[ADDR_W-1:`FSWG_PAGE_SHIFT], 9'h000};
					if (REQ_PAGES_IN == 6'h00) begin
						s_d.pages = 6'h01;
					end else if (REQ_PAGES_IN > 6'(`FSWG_ERASE_MAX_PAGES)) begin
						s_d.pages = 6'(`FSWG_ERASE_MAX_PAGES);
					end else begin
						s_d.pages = REQ_PAGES_IN;
					end
				end else if (REQ_OP_IN == FSWG_OP_WRITE_WORD && is_flash) begin
					s_d.addr = {REQ_ADDR_IN[ADDR_W-1:1], 1'b0};
				end
				if (is_flash && !REQ_DEBUG_IN) begin
					s_d.busy = 1'b1;
					s_d.cnt = 16'(PROG_CYC);
				end else begin
					s_d.accept = 1'b1;
				end
			end
		end
		if (SRST_IN) begin
			s_d = '0;
		end
	end
	always_ff @(posedge CLK_SYS_IN) begin
		s_q <= s_d;
	end
	assign REQ_ACCEPT_OUT = s_q.accept;
	assign REQ_REFUSE_OUT = s_q.refuse;
	assign CPU_STALL_OUT = s_q.busy;
	assign MEM_PROG_OUT = s_q.prog;
	assign MEM_FLASH_OUT = s_q.flash;
	assign MEM_USER_ROW_OUT = s_q.user_row;
	assign MEM_ADDR_OUT = s_q.addr;
	assign MEM_PAGES_OUT = s_q.pages;
	assign LOADER_END_OUT = s_q.loader_end;
	assign APP_CODE_END_OUT = s_q.app_code_end;
	// Vector table base
	assign VECTOR_BASE_OUT = VECTOR_RELOCATE_BIT_IN ? '0 : s_q.loader_end[ADDR_W-1:0];
	assign EXEC_SEC_OUT = exec_sec;

	// Section and write checks
	a_refuse_no_prog: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		REQ_REFUSE_OUT |-> !MEM_PROG_OUT && !CPU_STALL_OUT)
		else $error("refused write programmed or stalled");
	a_data_run_refused: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN
		&& exec_sec == FSWG_SEC_DATA |=> REQ_REFUSE_OUT)
		else $error("write from data section not refused");
	a_own_section: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && !REQ_EEPROM_IN
		&& !REQ_USER_ROW_IN && tgt_sec == exec_sec |=> REQ_REFUSE_OUT)
		else $error("write to executing section not refused");
	a_code_from_code: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && is_flash
		&& tgt_sec == FSWG_SEC_CODE && exec_sec != FSWG_SEC_LOADER |=> REQ_REFUSE_OUT)
		else $error("code section write from non-loader");
	a_data_from_loader: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && is_flash
		&& !REQ_CHIP_ERASE_IN && tgt_sec == FSWG_SEC_DATA
		&& exec_sec == FSWG_SEC_LOADER |=> MEM_PROG_OUT && CPU_STALL_OUT)
		else $error("permitted data write not stalled");
	a_eeprom_no_stall: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		MEM_PROG_OUT && !MEM_FLASH_OUT |-> !CPU_STALL_OUT && REQ_ACCEPT_OUT)
		else $error("EEPROM write stalled core");
	a_erase_aligned: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		MEM_PROG_OUT && MEM_PAGES_OUT > 6'h01 |-> MEM_ADDR_OUT[8:0] == 9'h000)
		else $error("multi-page erase not page aligned");
	a_loader_zero: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		$rose(s_q.loaded) && $past(LOADER_SIZE_FUSE_IN) == 8'h00
		|-> LOADER_END_OUT == FLASH_END_B && APP_CODE_END_OUT == FLASH_END_B)
		else $error("zero loader fuse not whole flash");
	a_stall_ends: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		$rose(CPU_STALL_OUT) |-> CPU_STALL_OUT [*8] ##[0:1000] REQ_ACCEPT_OUT)
		else $error("flash stall did not end with accept");
	a_word_aligned: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && allowed && is_flash
		&& REQ_OP_IN == FSWG_OP_WRITE_WORD |=> MEM_PROG_OUT && !MEM_ADDR_OUT[0])
		else $error("word write address not even");
	a_erase_pages: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && allowed && REQ_OP_IN == FSWG_OP_ERASE
		|=> MEM_PROG_OUT && MEM_PAGES_OUT != 6'h00 && MEM_PAGES_OUT <= 6'h20
		&& MEM_ADDR_OUT[8:0] == 9'h000)
		else $error("erase not on whole pages");
	a_loader_target: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && is_flash
		&& tgt_sec == FSWG_SEC_LOADER |=> REQ_REFUSE_OUT && !MEM_PROG_OUT)
		else $error("loader section write not refused");
	a_chip_erase_guard: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN
		&& REQ_CHIP_ERASE_IN |=> REQ_REFUSE_OUT)
		else $error("chip erase outside debug not refused");
	a_debug_no_stall: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && REQ_DEBUG_IN
		|=> REQ_ACCEPT_OUT && MEM_PROG_OUT && !CPU_STALL_OUT)
		else $error("debug write stalled or refused");
	a_eeprom_runs: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && REQ_EEPROM_IN
		&& !REQ_CHIP_ERASE_IN && exec_sec != FSWG_SEC_DATA |=> REQ_ACCEPT_OUT && !CPU_STALL_OUT)
		else $error("EEPROM write not accepted at once");
	a_user_row_runs: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded && !s_q.busy && REQ_VALID_IN && !REQ_DEBUG_IN && REQ_USER_ROW_IN
		&& !REQ_CHIP_ERASE_IN && exec_sec != FSWG_SEC_DATA |=> MEM_USER_ROW_OUT && REQ_ACCEPT_OUT)
		else $error("user row write not accepted");
	a_code_zero: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		$rose(s_q.loaded) && LOADER_END_OUT != FLASH_END_B
		&& $past(CODE_SIZE_FUSE_IN) == 8'h00 |-> APP_CODE_END_OUT == FLASH_END_B)
		else $error("zero code fuse did not run code to end");
	a_code_removed: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		$rose(s_q.loaded) && LOADER_END_OUT != FLASH_END_B
		&& $past(CODE_SIZE_FUSE_IN) != 8'h00
		&& $past(CODE_SIZE_FUSE_IN) <= $past(LOADER_SIZE_FUSE_IN) |-> APP_CODE_END_OUT == LOADER_END_OUT)
		else $error("small code fuse kept a code section");
	a_fuse_default: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		$rose(s_q.loaded) && $past(LOADER_SIZE_FUSE_IN) > 8'(FLASH_PAGES)
		|-> LOADER_END_OUT == FLASH_END_B)
		else $error("oversized loader fuse not replaced");
	a_sections_ordered: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		s_q.loaded |-> LOADER_END_OUT <= APP_CODE_END_OUT && APP_CODE_END_OUT <= FLASH_END_B)
		else $error("section boundaries out of order");
	a_reset_quiet: assert property (@(posedge CLK_SYS_IN)
		SRST_IN |=> !REQ_ACCEPT_OUT && !REQ_REFUSE_OUT && !CPU_STALL_OUT && !MEM_PROG_OUT)
		else $error("outputs active after reset");
	a_accept_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		REQ_ACCEPT_OUT |=> !REQ_ACCEPT_OUT)
		else $error("accept longer than one cycle");
	a_refuse_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		REQ_REFUSE_OUT |=> !REQ_REFUSE_OUT && !MEM_PROG_OUT)
		else $error("refuse longer than one cycle");
	a_stall_flash: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		CPU_STALL_OUT |-> MEM_FLASH_OUT)
		else $error("stall without flash target");
	a_busy_no_take: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
		CPU_STALL_OUT |=> !MEM_PROG_OUT)
		else $error("request taken while stalled");

	// Main scenarios
	c_refuse: cover property (@(posedge CLK_SYS_IN) REQ_REFUSE_OUT);
	c_flash_prog: cover property (@(posedge CLK_SYS_IN) $fell(CPU_STALL_OUT));
	c_eeprom: cover property (@(posedge CLK_SYS_IN) MEM_PROG_OUT && !MEM_FLASH_OUT);
	c_multi_erase: cover property (@(posedge CLK_SYS_IN) MEM_PROG_OUT && MEM_PAGES_OUT > 6'h01);
	c_debug_flash: cover property (@(posedge CLK_SYS_IN) MEM_FLASH_OUT && REQ_ACCEPT_OUT && MEM_PROG_OUT);
endmodule : fswg_guard

// File: src/fswg_regs.svh
// Constants for the flash section write guard: geometry, fuse defaults, timing.
// Assumes byte addresses into program Flash starting at zero.
`ifndef FSWG_REGS_SVH
`define FSWG_REGS_SVH
`define FSWG_PAGE_BYTES 512
`define FSWG_PAGE_SHIFT 9
`define FSWG_ADDR_W 16
`define FSWG_FLASH_PAGES 128
`define FSWG_LOADER_FUSE_DEF 8'h00
`define FSWG_CODE_FUSE_DEF 8'h00
`define FSWG_FLASH_PROG_NS 500
`define FSWG_CLK_NS 10
`define FSWG_FLASH_PROG_CYC ((`FSWG_FLASH_PROG_NS + `FSWG_CLK_NS - 1) / `FSWG_CLK_NS)
`define FSWG_ERASE_MAX_PAGES 32
`endif

// File: src/fswg_pkg.sv
// Types for the flash section write guard.
// Shared by the guard top and its section decoder.
package fswg_pkg;
	typedef enum logic [1:0] {
		FSWG_SEC_LOADER,
		FSWG_SEC_CODE,
		FSWG_SEC_DATA,
		FSWG_SEC_EEPROM
	} fswg_sec_t;
	typedef enum logic [1:0] {
		FSWG_OP_WRITE_BYTE,
		FSWG_OP_WRITE_WORD,
		FSWG_OP_ERASE
	} fswg_op_t;
endpackage : fswg_pkg

// File: src/fswg_sec_decode.sv
// Section decoder: maps a Flash byte address to its section.
// Assumes loader_end and app_code_end are page-aligned byte addresses.
`timescale 1ns/1ps
`include "fswg_regs.svh"
module fswg_sec_decode #(
	parameter int ADDR_W = `FSWG_ADDR_W
) (
	// Address and boundaries
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [ADDR_W:0] loader_end_in,
	input wire logic [ADDR_W:0] app_code_end_in,
	// Section
	output fswg_pkg::fswg_sec_t sec_out
);
	import fswg_pkg::*;
	always_comb begin
		if ({1'b0, addr_in} < loader_end_in) begin
			sec_out = FSWG_SEC_LOADER;
		end else if ({1'b0, addr_in} < app_code_end_in) begin
			sec_out = FSWG_SEC_CODE;
		end else begin
			sec_out = FSWG_SEC_DATA;
		end
	end
endmodule : fswg_sec_decode

// File: test/fswg_core_model.sv
// Core model: holds a fetch address and one write request until answered.
// Assumes registered accept/refuse pulses from the guard.
`timescale 1ns/1ps
module fswg_core_model (
	// Answer
	input wire logic clk_in,
	input wire logic accept_in,
	input wire logic refuse_in,
	input wire logic stall_in,
	input wire logic prog_in,
	// Request
	output logic [15:0] fetch_out,
	output logic valid_out,
	output fswg_pkg::fswg_op_t op_out,
	output logic ee_out,
	output logic ce_out,
	output logic dbg_out,
	output logic [15:0] addr_out,
	output logic [5:0] pages_out
);
	import fswg_pkg::*;
	initial begin
		{fetch_out, valid_out, ee_out, ce_out, dbg_out, addr_out, pages_out} = '0;
		op_out = FSWG_OP_WRITE_BYTE;
	end
	task automatic req(input logic [15:0] f, input fswg_op_t op, input logic [2:0] k,
			input logic [15:0] a, input logic [5:0] p, output logic ok, output int lat,
			output int st, output int pr);
		@(negedge clk_in);
		fetch_out = f;
		op_out = op;
		{dbg_out, ce_out, ee_out} = k;
		addr_out = a;
		pages_out = p;
		valid_out = 1'b1;
		lat = 0;
		st = 0;
		pr = 0;
		while (lat < 200 && !(accept_in || refuse_in)) begin
			@(posedge clk_in);
			#1;
			lat++;
			st += stall_in;
			pr += prog_in;
		end
		ok = accept_in;
		@(negedge clk_in);
		valid_out = 1'b0;
		addr_out = ~addr_out;
	endtask : req
endmodule : fswg_core_model

// File: test/tb.sv
// Random bench for the flash section write guard with corner fuse settings.
// Assumes the guard's built-in assertions watch the ports.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
	import fswg_pkg::*;
	localparam int PC = 9;
	logic clk, srst, rel, valid, ee, ce, dbg, acc, rfs, stl, prg, ok, eo, se;
	logic ur, mfl, mur, m_fl, m_ur;
	logic [7:0] lf, cf;
	logic [15:0] fetch, addr, f, a, vb, mad, m_ad, xa;
	logic [16:0] le, cend, lo, co;
	logic [5:0] pages, mpg, m_pg, p, xp;
	logic [2:0] k;
	fswg_op_t op, o;
	fswg_sec_t sec, fs, ts;
	int mismatches = 0, num_checks = 0, lat, st, pr;
	logic [15:0] corner [9] = '{16'h0000, 16'h0408, 16'h0804, 16'h0400, 16'h0404,
		16'hc800, 16'h04c8, 16'h8000, 16'h0181};
	fswg_core_model u_core (.clk_in(clk), .accept_in(acc), .refuse_in(rfs), .stall_in(stl),
		.prog_in(prg), .fetch_out(fetch), .valid_out(valid), .op_out(op), .ee_out(ee),
		.ce_out(ce), .dbg_out(dbg), .addr_out(addr), .pages_out(pages));
	fswg_guard #(.PROG_CYC(PC)) u_dut (.CLK_SYS_IN(clk), .SRST_IN(srst),
		.LOADER_SIZE_FUSE_IN(lf), .CODE_SIZE_FUSE_IN(cf), .VECTOR_RELOCATE_BIT_IN(rel),
		.FETCH_ADDR_IN(fetch), .REQ_VALID_IN(valid), .REQ_OP_IN(op), .REQ_EEPROM_IN(ee),
		.REQ_CHIP_ERASE_IN(ce), .REQ_USER_ROW_IN(ur), .REQ_DEBUG_IN(dbg),
		.REQ_ADDR_IN(addr), .REQ_PAGES_IN(pages), .REQ_ACCEPT_OUT(acc), .REQ_REFUSE_OUT(rfs),
		.CPU_STALL_OUT(stl), .MEM_PROG_OUT(prg), .MEM_FLASH_OUT(mfl), .MEM_USER_ROW_OUT(mur),
		.MEM_ADDR_OUT(mad), .MEM_PAGES_OUT(mpg), .LOADER_END_OUT(lo), .APP_CODE_END_OUT(co),
		.VECTOR_BASE_OUT(vb), .EXEC_SEC_OUT(sec));
	// Latch what the strobe carried, after it has settled
	always @(posedge clk) begin
		#1;
		if (prg)
			{m_fl, m_ur, m_ad, m_pg} = {mfl, mur, mad, mpg};
	end
	function automatic logic [16:0] end_of(input logic [7:0] l, input logic [7:0] c,
			input bit code);
		logic [16:0] e;
		e = (l == 0 || l > 128) ? 17'h10000 : {l, 9'h000};
		if (!code || e == 17'h10000)
			return e;
		return (c == 0 || c > 128) ? 17'h10000 : (c <= l ? e : {c, 9'h000});
	endfunction : end_of
	function automatic fswg_sec_t sec_of(input logic [15:0] x);
		return x < le ? FSWG_SEC_LOADER : (x < cend ? FSWG_SEC_CODE : FSWG_SEC_DATA);
	endfunction : sec_of
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200_000;
		mismatches++;
		print_verdict();
	end
	initial begin
		srst = 1;
		rel = 0;
		ur = 0;
		{lf, cf} = 16'h0000;
		void'($urandom(82883));
		repeat (20) @(negedge clk);
		for (int i = 0; i < 40; i++) begin
			{lf, cf} = i < 9 ? corner[i] : 16'($urandom);
			srst = 1;
			@(negedge clk);
			srst = 0;
			@(negedge clk);
			le = end_of(lf, cf, 0);
			cend = end_of(lf, cf, 1);
			`CHK(lo, le)
			`CHK(co, cend)
			for (int j = 0; j < 8; j++) begin
				f = $urandom;
				a = $urandom;
				k = {$urandom_range(7) == 0, $urandom_range(7) == 0, 1'($urandom)};
				rel = $urandom;
				ur = $urandom_range(7) == 0;
				o = fswg_op_t'($urandom_range(2));
				p = 6'($urandom);
				u_core.req(f, o, k, a, p, ok, lat, st, pr);
				fs = sec_of(f);
				ts = sec_of(a);
				eo = k[2] || (!k[1] && fs != FSWG_SEC_DATA && (k[0] || ur || (ts != fs &&
					ts != FSWG_SEC_LOADER && (ts == FSWG_SEC_DATA || fs == FSWG_SEC_LOADER))));
				se = eo && !k[0] && !ur && !k[2];
				xa = o == FSWG_OP_ERASE ? {a[15:9], 9'h000} :
					((o == FSWG_OP_WRITE_WORD && !k[0] && !ur) ? {a[15:1], 1'b0} : a);
				xp = o != FSWG_OP_ERASE ? 6'h01 : (p == 6'h00 ? 6'h01 : (p > 6'h20 ? 6'h20 : p));
				if (eo) begin
					`CHK(m_ad, xa)
					`CHK(m_pg, xp)
					`CHK({m_fl, m_ur}, {!k[0] && !ur, ur})
				end
				`CHK(sec, fs)
				`CHK(vb, rel ? 16'h0000 : le[15:0])
				`CHK(ok, eo)
				`CHK(lat, se ? PC + 1 : 1)
				`CHK(st, se ? PC : 0)
				`CHK(pr, int'(eo))
			end
		end
		print_verdict();
	end
endmodule : tb
